// File: vic_pkg.sv
// Purpose: shared constants of the vectored interrupt controller
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes: offsets are byte offsets within the block
package vic_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int VIC_NSRC = 32;
  localparam int VIC_IDXW = 5;
  localparam int VIC_OFFW = 12;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [11:0] VIC_NORMAL_STATUS = 12'h000;
  localparam logic [11:0] VIC_FAST_STATUS = 12'h004;
  localparam logic [11:0] VIC_RAW_STATUS = 12'h008;
  localparam logic [11:0] VIC_FAST_SELECT = 12'h00c;
  localparam logic [11:0] VIC_ENABLE = 12'h010;
  localparam logic [11:0] VIC_ENABLE_CLEAR = 12'h014;
  localparam logic [11:0] VIC_SOFT_REQ = 12'h018;
  localparam logic [11:0] VIC_SOFT_CLEAR = 12'h01c;
  localparam logic [11:0] VIC_ACTIVE_VECTOR = 12'h030;
  localparam logic [11:0] VIC_DEFAULT_VECTOR = 12'h034;
  localparam logic [11:0] VIC_MAP_CONTROL = 12'h040;
  localparam logic [11:0] VIC_SLOT_ADDR_BASE = 12'h100;
  localparam logic [11:0] VIC_SLOT_CTRL_BASE = 12'h200;

  // ****************************************
  // slot control word fields
  // ****************************************
  localparam int VIC_SLOT_IDX_LSB = 0;
  localparam int VIC_SLOT_EN_BIT = 5;
  localparam int VIC_SLOT_CTRLW = 6;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] VIC_RST_WORD = 32'h0000_0000;
  localparam logic [5:0] VIC_RST_SLOT_CTRL = 6'h00;
  localparam logic [1:0] VIC_RST_MAP = 2'h0;

  // ****************************************
  // memory map control and vector placement
  // ****************************************
  localparam logic [1:0] VIC_MAP_USER_RAM = 2'h2;
  localparam logic [31:0] VIC_VEC_BASE_LOW = 32'h0000_0000;
  localparam logic [31:0] VIC_VEC_BASE_RAM = 32'h4000_0000;

  // ****************************************
  // bus encodings
  // ****************************************
  localparam logic [1:0] VIC_HTRANS_NONSEQ = 2'h2;

endpackage

// File: vic_slot.sv
// Purpose: one vectored priority slot: control word, routine address, match
// Assumes: written by the register decoder of vic_top
// Notes: match uses only enabled normal-class requests
`timescale 1ns/100ps
module vic_slot
  import vic_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ctrl_we,
  input wire logic addr_we,
  input wire logic [31:0] wdata,
  input wire logic [VIC_NSRC-1:0] normal_status,
  output logic [VIC_SLOT_CTRLW-1:0] ctrl,
  output logic [31:0] vec_addr,
  output logic hit
);
  logic [VIC_SLOT_CTRLW-1:0] ctrl_q;
  logic [VIC_SLOT_CTRLW-1:0] ctrl_d;
  logic [31:0] addr_q;
  logic [31:0] addr_d;
  logic [VIC_IDXW-1:0] src_idx;

  always_comb begin
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    if (ctrl_we) begin
      ctrl_d = wdata[VIC_SLOT_CTRLW-1:0];
    end
    if (addr_we) begin
      addr_d = wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= VIC_RST_SLOT_CTRL;
      addr_q <= VIC_RST_WORD;
    end else begin
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
    end
  end

  assign src_idx = ctrl_q[VIC_SLOT_IDX_LSB +: VIC_IDXW];
  assign hit = ctrl_q[VIC_SLOT_EN_BIT] & normal_status[src_idx];
  assign ctrl = ctrl_q;
  assign vec_addr = addr_q;
endmodule

// File: vic_top.sv
// Purpose: vectored interrupt controller with AHB-Lite register slave
// Assumes: request lines synchronous to hclk, active high levels
// Notes: zero wait state slave, response always OKAY
//
// Behaviour
// - user RAM mode moves vectors to RAM
// - any sources may be fast, status shows them
// - select bit zero means normal class
// - status bits follow the request lines
// - vector write ends service, blocks until then
// - enable-clear ones mask sources, zeros ignored
// - soft-clear ones clear only those soft bits
// - clear bit acts once until rewritten zero
// - disabled source leaves outputs despite raw request
// - enable bit position equals source index
// - slot word holds index and enable bit
// - lower slot number ranks higher
// - active vector reachable by pc-relative load
// - read gives highest active slot address
// - unslotted normal sources give default address
// - lost request reads back default address
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module vic_top
  import vic_pkg::*;
#(
  parameter int NSLOT = 16
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [VIC_NSRC-1:0] src_req,
  output logic fast_req,
  output logic normal_req,
  output logic [31:0] vector_base
);
  import vic_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [31:0] fast_select_q;
  logic [31:0] fast_select_d;
  logic [31:0] enable_q;
  logic [31:0] enable_d;
  logic [31:0] soft_req_q;
  logic [31:0] soft_req_d;
  logic [31:0] soft_clear_q;
  logic [31:0] soft_clear_d;
  logic [31:0] default_vec_q;
  logic [31:0] default_vec_d;
  logic [1:0] map_q;
  logic [1:0] map_d;
  logic in_service_q;
  logic in_service_d;
  logic [31:0] served_vec_q;
  logic [31:0] served_vec_d;
  logic fast_req_q;
  logic fast_req_d;
  logic normal_req_q;
  logic normal_req_d;
  logic [31:0] vector_base_q;
  logic [31:0] vector_base_d;

  // bus state
  logic wr_pend_q;
  logic wr_pend_d;
  logic [VIC_OFFW-1:0] wr_off_q;
  logic [VIC_OFFW-1:0] wr_off_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // ****************************************
  // request status
  // ****************************************
  logic [31:0] raw_status;
  logic [31:0] fast_status;
  logic [31:0] normal_status;

  assign raw_status = src_req | soft_req_q;
  assign fast_status = raw_status & enable_q & fast_select_q;
  assign normal_status = raw_status & enable_q & ~fast_select_q;

  // ****************************************
  // vectored slots
  // ****************************************
  logic [NSLOT-1:0] slot_hit;
  logic [NSLOT-1:0] slot_ctrl_we;
  logic [NSLOT-1:0] slot_addr_we;
  logic [31:0] slot_addr [NSLOT];
  logic [VIC_SLOT_CTRLW-1:0] slot_ctrl [NSLOT];

  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    assign slot_ctrl_we[s] = wr_pend_q &&
      (wr_off_q == VIC_SLOT_CTRL_BASE + VIC_OFFW'(4 * s));
    assign slot_addr_we[s] = wr_pend_q &&
      (wr_off_q == VIC_SLOT_ADDR_BASE + VIC_OFFW'(4 * s));
    vic_slot u_slot (
      .hclk(hclk),
      .hresetn(hresetn),
      .ctrl_we(slot_ctrl_we[s]),
      .addr_we(slot_addr_we[s]),
      .wdata(hwdata),
      .normal_status(normal_status),
      .ctrl(slot_ctrl[s]),
      .vec_addr(slot_addr[s]),
      .hit(slot_hit[s])
    );
  end

  // ****************************************
  // priority resolution
  // ****************************************
  // scanning from the top slot down lets slot 0 overwrite everything else
  logic [31:0] live_vec;

  always_comb begin
    live_vec = default_vec_q;
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (slot_hit[i]) begin
        live_vec = slot_addr[i];
      end
    end
  end

  // ****************************************
  // bus decode
  // ****************************************
  logic addr_phase;
  logic [VIC_OFFW-1:0] a_off;
  logic rd_now;

  assign addr_phase = hsel && hready && (htrans == VIC_HTRANS_NONSEQ);
  assign a_off = haddr[VIC_OFFW-1:0];
  assign rd_now = addr_phase && !hwrite;

  function automatic logic [31:0] slot_read(input logic [VIC_OFFW-1:0] off);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < NSLOT; i++) begin
      if (off == VIC_SLOT_ADDR_BASE + VIC_OFFW'(4 * i)) begin
        r = slot_addr[i];
      end
      if (off == VIC_SLOT_CTRL_BASE + VIC_OFFW'(4 * i)) begin
        r = {26'h0, slot_ctrl[i]};
      end
    end
    return r;
  endfunction

  // read data is fetched in the address phase so it stands in the data phase
  always_comb begin
    rdata_d = rdata_q;
    if (rd_now) begin
      unique case (a_off)
        VIC_NORMAL_STATUS: rdata_d = normal_status;
        VIC_FAST_STATUS: rdata_d = fast_status;
        VIC_RAW_STATUS: rdata_d = raw_status;
        VIC_FAST_SELECT: rdata_d = fast_select_q;
        VIC_ENABLE: rdata_d = enable_q;
        VIC_SOFT_REQ: rdata_d = soft_req_q;
        VIC_SOFT_CLEAR: rdata_d = soft_clear_q;
        VIC_ACTIVE_VECTOR: rdata_d = in_service_q ? served_vec_q : live_vec;
        VIC_DEFAULT_VECTOR: rdata_d = default_vec_q;
        VIC_MAP_CONTROL: rdata_d = {30'h0, map_q};
        default: rdata_d = slot_read(a_off);
      endcase
    end
  end

  always_comb begin
    wr_pend_d = addr_phase && hwrite;
    wr_off_d = addr_phase ? a_off : wr_off_q;
  end

  // ****************************************
  // control registers
  // ****************************************
  logic [31:0] soft_clr_effect;

  // only bits rising in the clear register act on the soft requests
  assign soft_clr_effect = hwdata & ~soft_clear_q;

  always_comb begin
    fast_select_d = fast_select_q;
    enable_d = enable_q;
    soft_req_d = soft_req_q;
    soft_clear_d = soft_clear_q;
    default_vec_d = default_vec_q;
    map_d = map_q;
    if (wr_pend_q) begin
      unique case (wr_off_q)
        VIC_FAST_SELECT: fast_select_d = hwdata;
        VIC_ENABLE: enable_d = enable_q | hwdata;
        VIC_ENABLE_CLEAR: enable_d = enable_q & ~hwdata;
        VIC_SOFT_REQ: soft_req_d = soft_req_q | hwdata;
        VIC_SOFT_CLEAR: begin
          soft_req_d = soft_req_q & ~soft_clr_effect;
          soft_clear_d = hwdata;
        end
        VIC_DEFAULT_VECTOR: default_vec_d = hwdata;
        VIC_MAP_CONTROL: map_d = hwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // in-service tracking
  // ****************************************
  // the core's vector read opens service; the return-time write closes it
  always_comb begin
    in_service_d = in_service_q;
    served_vec_d = served_vec_q;
    if (wr_pend_q && (wr_off_q == VIC_ACTIVE_VECTOR)) begin
      in_service_d = 1'b0;
    end
    if (rd_now && (a_off == VIC_ACTIVE_VECTOR) && !in_service_q && normal_req_q) begin
      in_service_d = 1'b1;
      served_vec_d = live_vec;
    end
  end

  // ****************************************
  // core request outputs
  // ****************************************
  // a normal request waits while one is in service; fast is never held off
  always_comb begin
    fast_req_d = |fast_status;
    normal_req_d = (|normal_status) && !in_service_d;
    vector_base_d = (map_q == VIC_MAP_USER_RAM) ? VIC_VEC_BASE_RAM
                                                : VIC_VEC_BASE_LOW;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_select_q <= VIC_RST_WORD;
      enable_q <= VIC_RST_WORD;
      soft_req_q <= VIC_RST_WORD;
      soft_clear_q <= VIC_RST_WORD;
      default_vec_q <= VIC_RST_WORD;
      map_q <= VIC_RST_MAP;
      in_service_q <= 1'b0;
      served_vec_q <= VIC_RST_WORD;
      fast_req_q <= 1'b0;
      normal_req_q <= 1'b0;
      vector_base_q <= VIC_VEC_BASE_LOW;
      wr_pend_q <= 1'b0;
      wr_off_q <= 12'h000;
      rdata_q <= VIC_RST_WORD;
    end else begin
      fast_select_q <= fast_select_d;
      enable_q <= enable_d;
      soft_req_q <= soft_req_d;
      soft_clear_q <= soft_clear_d;
      default_vec_q <= default_vec_d;
      map_q <= map_d;
      in_service_q <= in_service_d;
      served_vec_q <= served_vec_d;
      fast_req_q <= fast_req_d;
      normal_req_q <= normal_req_d;
      vector_base_q <= vector_base_d;
      wr_pend_q <= wr_pend_d;
      wr_off_q <= wr_off_d;
      rdata_q <= rdata_d;
    end
  end

  // ready and response are constant registers: every transfer is zero-wait OKAY
  logic hready_q;
  logic hresp_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = hready_q;
  assign hresp = hresp_q;
  assign fast_req = fast_req_q;
  assign normal_req = normal_req_q;
  assign vector_base = vector_base_q;

  // hsize is unused: only whole-word single transfers are supported
  logic unused_hsize;
  assign unused_hsize = ^hsize;
endmodule

// File: vic_top_assertions.sv
// Purpose: port checker of vic_top
// Assumes: hready is tied to hreadyout
// Notes: in-service state rebuilt from bus traffic
`timescale 1ns/100ps
module vic_top_assertions
  import vic_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [VIC_NSRC-1:0] src_req,
  input wire logic fast_req,
  input wire logic normal_req,
  input wire logic [31:0] vector_base
);
  // ****
  // helpers
  // ****
  logic take;
  logic vrd;
  logic act_q;
  logic w_q;
  logic [11:0] a_q;
  logic svc_q;
  logic svc_d;
  assign take = hsel & hready & (htrans == VIC_HTRANS_NONSEQ);
  assign vrd = take & !hwrite & (haddr[11:0] == VIC_ACTIVE_VECTOR);
  // a clear in the data phase wins over nothing; set only while a request stands
  always_comb begin
    svc_d = svc_q;
    if (act_q && w_q && a_q == VIC_ACTIVE_VECTOR) begin
      svc_d = 1'h0;
    end
    if (vrd && normal_req) begin
      svc_d = 1'h1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_q <= 1'h0;
      w_q <= 1'h0;
      a_q <= 12'h0;
      svc_q <= 1'h0;
    end else begin
      act_q <= take;
      w_q <= hwrite;
      a_q <= haddr[11:0];
      svc_q <= svc_d;
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_VBASE_VALUE: assert property (vector_base == VIC_VEC_BASE_LOW || vector_base == VIC_VEC_BASE_RAM)
    else $error("vector base off its two values");
  AST_VBASE_CAUSE: assert property ($changed(vector_base) |-> $past(act_q) || $past(act_q, 2))
    else $error("vector base moved without a write");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("slave stalled or answered an error");
  AST_SVC_DROP: assert property (vrd && normal_req |-> ##2 !normal_req)
    else $error("normal request stayed up after vector read");
  AST_SVC_HOLD: assert property (svc_q && $past(svc_q) |-> !normal_req)
    else $error("normal request raised while in service");
  AST_FAST_CAUSE: assert property ($changed(fast_req) |->
    $past(act_q) || $past(act_q, 2) || $past(src_req) != $past(src_req, 2))
    else $error("fast request moved without cause");
  AST_NORMAL_CAUSE: assert property ($changed(normal_req) |->
    $past(take) || $past(act_q) || $past(act_q, 2) || $past(src_req) != $past(src_req, 2))
    else $error("normal request moved without cause");
  AST_RDATA_CAUSE: assert property ($changed(hrdata) |-> $past(take && !hwrite))
    else $error("read data moved without a read");
endmodule

bind vic_top vic_top_assertions i_vic_top_assertions (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .src_req, .fast_req, .normal_req, .vector_base);

// File: vic_core_model.sv
// Purpose: behavioural processor core taking normal requests
// Assumes: requests are registered levels
// Notes: only the vector fetch and the handler load address are modelled
`timescale 1ns/100ps
module vic_core_model
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic normal_req,
  input wire logic [31:0] vector_base,
  output logic [31:0] fetch_addr,
  output logic [31:0] load_addr
);
  // pc reads eight ahead of the fetch, hence the extra 8
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_addr <= 32'h0;
      load_addr <= 32'h0;
    end else if (normal_req) begin
      fetch_addr <= vector_base + 32'h18;
      load_addr <= 32'h18 + 32'h8 - 32'hff0;
    end
  end
endmodule

// File: vic_top_tb.sv
// Purpose: directed test of vic_top
// Assumes: hready looped back from hreadyout
// Notes: hsize fixed to word
`timescale 1ns/100ps
module vic_top_tb;
  import vic_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, fast_req, normal_req;
  logic [31:0] haddr, hwdata, hrdata, vector_base, fetch_addr, load_addr, src_req, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int n_mismatch, cmp_count;
  vic_top i_vic_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .src_req, .fast_req, .normal_req,
    .vector_base);
  vic_core_model i_vic_core_model (.hclk, .hresetn, .normal_req, .vector_base, .fetch_addr,
    .load_addr);
  initial begin
    hclk = 1'h0;
    forever #25 hclk = ~hclk;
  end
  // ****
  // helpers
  // ****
  task automatic complete_run;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      n_mismatch++;
    end
  endtask
  // bounded wait, so a stuck slave ends the run instead of hanging it
  task automatic rdy;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'h1 && i < 20);
    if (hreadyout !== 1'h1) begin
      n_mismatch++;
      complete_run;
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= VIC_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {20'h0, a};
    rdy;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic tk;
    repeat (2) @(posedge hclk);
    #1;
  endtask
  task automatic sr(input logic [31:0] v);
    @(posedge hclk);
    src_req <= v;
    tk;
  endtask
  // ****
  // scenarios
  // ****
  task automatic sc_reset;
    chk("req", {30'h0, fast_req, normal_req}, 32'h0);
    chk("vbase", vector_base, VIC_VEC_BASE_LOW);
    chk("okay", {30'h0, hreadyout, hresp}, 32'h2);
    rc("enable", VIC_ENABLE, VIC_RST_WORD);
    rc("unmapped", 12'h080, 32'h0);
  endtask
  task automatic sc_normal;
    bus(1'h1, VIC_FAST_SELECT, 32'h0);
    bus(1'h1, VIC_ENABLE, 32'h6c0);
    bus(1'h1, VIC_DEFAULT_VECTOR, 32'h1000);
    rc("enable", VIC_ENABLE, 32'h6c0);
    sr(32'h200);
    chk("req", {30'h0, fast_req, normal_req}, 32'h1);
    chk("fetch", fetch_addr, 32'h18);
    chk("load", {20'h0, load_addr[11:0]}, {20'h0, VIC_ACTIVE_VECTOR});
    rc("normal", VIC_NORMAL_STATUS, 32'h200);
    rc("vec", VIC_ACTIVE_VECTOR, 32'h1000);
    sr(32'h600);
    chk("svc", {31'h0, normal_req}, 32'h0);
    bus(1'h1, VIC_ACTIVE_VECTOR, 32'h0);
    tk;
    chk("svc", {31'h0, normal_req}, 32'h1);
    sr(32'h0);
    chk("norm", {31'h0, normal_req}, 32'h0);
    rc("raw", VIC_RAW_STATUS, 32'h0);
  endtask
  task automatic sc_slots;
    bus(1'h1, VIC_SLOT_CTRL_BASE, 32'h26);
    bus(1'h1, VIC_SLOT_CTRL_BASE + 12'h4, 32'h2a);
    bus(1'h1, VIC_SLOT_ADDR_BASE, 32'h2000);
    bus(1'h1, VIC_SLOT_ADDR_BASE + 12'h4, 32'h3000);
    rc("ctl1", VIC_SLOT_CTRL_BASE + 12'h4, 32'h2a);
    sr(32'h400);
    rc("vec", VIC_ACTIVE_VECTOR, 32'h3000);
    bus(1'h1, VIC_ACTIVE_VECTOR, 32'h0);
    sr(32'h440);
    rc("vec", VIC_ACTIVE_VECTOR, 32'h2000);
    bus(1'h1, VIC_ACTIVE_VECTOR, 32'h0);
    sr(32'h0);
    rc("vec", VIC_ACTIVE_VECTOR, 32'h1000);
  endtask
  task automatic sc_fast;
    bus(1'h1, VIC_FAST_SELECT, 32'h80);
    sr(32'h80);
    chk("req", {30'h0, fast_req, normal_req}, 32'h2);
    rc("fast", VIC_FAST_STATUS, 32'h80);
    bus(1'h1, VIC_ENABLE_CLEAR, 32'h80);
    tk;
    chk("fastreq", {31'h0, fast_req}, 32'h0);
    rc("raw", VIC_RAW_STATUS, 32'h80);
    rc("enable", VIC_ENABLE, 32'h640);
    sr(32'h0);
  endtask
  task automatic sc_soft;
    bus(1'h1, VIC_ENABLE, 32'h5);
    bus(1'h1, VIC_SOFT_REQ, 32'h5);
    tk;
    chk("norm", {31'h0, normal_req}, 32'h1);
    bus(1'h1, VIC_SOFT_CLEAR, 32'h1);
    rc("soft", VIC_SOFT_REQ, 32'h4);
    bus(1'h1, VIC_SOFT_REQ, 32'h1);
    bus(1'h1, VIC_SOFT_CLEAR, 32'h1);
    rc("soft", VIC_SOFT_REQ, 32'h5);
    bus(1'h1, VIC_SOFT_CLEAR, 32'h0);
    bus(1'h1, VIC_SOFT_CLEAR, 32'h5);
    rc("soft", VIC_SOFT_REQ, 32'h0);
    tk;
    chk("norm", {31'h0, normal_req}, 32'h0);
  endtask
  task automatic sc_map;
    bus(1'h1, VIC_MAP_CONTROL, {30'h0, VIC_MAP_USER_RAM});
    tk;
    chk("vbase", vector_base, VIC_VEC_BASE_RAM);
    sr(32'h200);
    chk("fetch", fetch_addr, 32'h4000_0018);
    sr(32'h0);
    bus(1'h1, VIC_MAP_CONTROL, 32'h0);
    tk;
    chk("vbase", vector_base, VIC_VEC_BASE_LOW);
  endtask
  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    src_req = 32'h0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    tk;
    sc_reset;
    sc_normal;
    sc_slots;
    sc_fast;
    sc_soft;
    sc_map;
    complete_run;
  end
endmodule
